//--- core/wdt_pkg.sv
// constants, register map and rate table for the windowed watchdog
//
// What this block does
// - end of period without service requests reset
// - rate code zero keeps counter stopped
// - wait mode counts unless wait_stop; then reinitialises
// - stop mode counts only with stop_run set
// - rate code maps to 2^6 .. 2^16 cycles
// - nonzero rate write enables, starts fresh period
// - restart on accepted rate write or debug_stop rise
// - control fields write once outside special modes
// - debug_stop sticky outside special modes, clearable only in special modes
// - debug_stop halts counter during active debug
// - write_mask reads zero, masks control fields except debug_stop
// - window mode: early arm write resets part
// - repeated 55 allowed; AA restarts, then wait
// - forced longest normal timeout in special debug
// - arm register reads zero, write only
// - special single chip reset gives maximum rate
// - reset loads inverted option field and window
// - bad arm value resets part immediately
// - arm writes ignored while watchdog disabled
// - counter runs on reference clock, not bus
package wdt_pkg;
   localparam int          ADDR_W     = 12;
   localparam int          CNT_W      = 17;
   localparam logic [9:0]  CTL_IDX    = 10'h03E;
   localparam logic [9:0]  ARM_IDX    = 10'h03F;
   localparam logic [9:0]  STAT_IDX   = 10'h040;
   localparam int          BIT_WIN    = 7;
   localparam int          BIT_DSTOP  = 6;
   localparam int          BIT_MASK   = 5;
   localparam int          BIT_WSTOP  = 4;
   localparam int          BIT_SRUN   = 3;
   localparam int          RATE_MSB   = 2;
   localparam logic [7:0]  ARM_KEY1   = 8'h55;
   localparam logic [7:0]  ARM_KEY2   = 8'hAA;
   localparam logic [2:0]  RATE_OFF   = 3'h0;
   localparam logic [2:0]  RATE_MAX   = 3'h7;
   localparam logic [4:0]  SHIFT_MAX  = 5'h10;
   localparam int          REF_DIV    = 4;
   localparam logic [1:0]  STRAP_WAIT = 2'h3;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // timeout exponent for each rate code
   function automatic logic [4:0] shift_for(input logic [2:0] rate);
      logic [4:0] s;
      s = 5'h00;
      case (rate)
         3'h1: s = 5'h06;
         3'h2: s = 5'h08;
         3'h3: s = 5'h0A;
         3'h4: s = 5'h0C;
         3'h5: s = 5'h0E;
         3'h6: s = 5'h0F;
         3'h7: s = 5'h10;
         default: s = 5'h00;
      endcase
      return s;
   endfunction
endpackage

//--- core/wdt_counter.sv
// watchdog period counter with window detection
`timescale 1ns/100ps
module wdt_counter
#(
   parameter int CW = wdt_pkg::CNT_W
) (
   input  wire logic          clk_sys,
   input  wire logic          reset_n,
   input  wire logic          tick,
   input  wire logic          run,
   input  wire logic          clear,
   input  wire logic [4:0]    shift,
   output logic      [CW-1:0] count,
   output logic               expire,
   output logic               win_open
);
   import wdt_pkg::*;

   logic [CW-1:0] count_r;
   logic [CW-1:0] period;
   logic [CW-1:0] last;
   logic [CW-1:0] win_start;

   assign period    = {{(CW-1){1'b0}}, 1'b1} << shift;
   assign last      = period - {{(CW-1){1'b0}}, 1'b1};
   // window is the final quarter of the period
   assign win_start = period - (period >> 2);
   // a shorter period taken mid-count expires at once, never wraps
   assign expire    = tick & run & ~clear & (count_r >= last);
   assign win_open  = (count_r >= win_start);
   assign count     = count_r;

   // counts reference ticks only, never bus cycles
   always_ff @(posedge clk_sys) begin
      if (!reset_n || clear || expire) begin
         count_r <= '0;
      end else if (tick && run) begin
         count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule

//--- core/wdt_top.sv
// windowed watchdog timer with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module wdt_top
#(
   parameter int REF_DIVIDE = wdt_pkg::REF_DIV
) (
   input  wire logic                   clk_sys,
   input  wire logic                   reset_n,
   input  wire logic                   debug_mode,
   input  wire logic                   wait_mode,
   input  wire logic                   stop_mode,
   input  wire logic                   special_mode,
   input  wire logic [2:0]             option_rate_field,
   input  wire logic                   option_window_bit,
   input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic                        wdt_reset_req
);
   import wdt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [7:0]  sync1_r;
   logic [7:0]  sync2_r;
   logic        dbg;
   logic        wai;
   logic        stp;
   logic        spc;
   logic [2:0]  opt_rate;
   logic        opt_win;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= {option_window_bit, option_rate_field, special_mode,
                     stop_mode, wait_mode, debug_mode};
         sync2_r <= sync1_r;
      end
   end

   assign dbg      = sync2_r[0];
   assign wai      = sync2_r[1];
   assign stp      = sync2_r[2];
   assign spc      = sync2_r[3];
   assign opt_rate = sync2_r[6:4];
   assign opt_win  = sync2_r[7];

   ////////////////////////////////////////////////////////////////////////
   // reference tick divider
   logic [15:0] div_r;
   logic        tick;

   assign tick = (div_r == 16'(REF_DIVIDE - 1));

   always_ff @(posedge clk_sys) begin
      if (!reset_n || tick) begin
         div_r <= 16'h0000;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus slave
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [1:0]  rresp_r;
   logic [31:0] rdata_r;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_ctl;
   logic        wr_arm;
   logic        wr_stat;
   logic        rd_ctl;
   logic        rd_map;
   logic [7:0]  wd;
   logic [31:0] rd_word;

   // write address and data are taken together in one edge
   assign wr_fire = awready_r;
   assign rd_fire = arready_r;
   assign wd      = s_axi_wdata[7:0];
   assign wr_ctl  = wr_fire && s_axi_awaddr[11:2] == CTL_IDX && s_axi_wstrb[0];
   assign wr_arm  = wr_fire && s_axi_awaddr[11:2] == ARM_IDX && s_axi_wstrb[0];
   assign wr_stat = s_axi_awaddr[11:2] == STAT_IDX;
   assign rd_ctl  = s_axi_araddr[11:2] == CTL_IDX;
   assign rd_map  = rd_ctl || s_axi_araddr[11:2] == ARM_IDX
                    || s_axi_araddr[11:2] == STAT_IDX;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
         wready_r  <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (s_axi_awaddr[11:2] == CTL_IDX
                         || s_axi_awaddr[11:2] == ARM_IDX || wr_stat)
                        ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h00000000;
      end else begin
         arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
         if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= rd_word;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control state
   logic [2:0]  rate_r;
   logic        win_r;
   logic        dstop_r;
   logic        wstop_r;
   logic        srun_r;
   logic        once_r;
   logic        armed_r;
   logic        rst_req_r;
   logic [1:0]  strap_r;
   logic        enabled;
   logic        forced;
   logic        win_eff;
   logic [4:0]  shift_eff;
   logic        ctl_take;
   logic        ctl_restart;
   logic        dstop_nxt;
   logic        dstop_rise;
   logic        arm_bad;
   logic        arm_restart;
   logic        run;
   logic        clear;
   logic        expire;
   logic        win_open;
   logic [CNT_W-1:0] count;

   assign enabled   = (rate_r != RATE_OFF) && (strap_r == 2'h0);
   assign forced    = enabled && dbg && !dstop_r && spc;
   assign win_eff   = win_r && !forced;
   assign shift_eff = forced ? SHIFT_MAX : shift_for(rate_r);
   // write_mask set leaves guarded fields and the once flag alone
   assign ctl_take  = wr_ctl && !wd[BIT_MASK] && (spc || !once_r);
   assign ctl_restart = ctl_take && wd[RATE_MSB:0] != RATE_OFF;
   assign dstop_nxt = spc ? wd[BIT_DSTOP] : (dstop_r | wd[BIT_DSTOP]);
   assign dstop_rise = wr_ctl && dstop_nxt && !dstop_r;
   assign arm_bad   = wr_arm && enabled
                      && ((wd != ARM_KEY1 && wd != ARM_KEY2)
                          || (win_eff && !win_open));
   assign arm_restart = wr_arm && enabled && !arm_bad
                        && wd == ARM_KEY2 && armed_r;
   assign run       = enabled && !(dbg && dstop_r)
                      && !(wai && wstop_r)
                      && !(stp && !srun_r);
   assign clear     = !enabled || arm_restart || ctl_restart
                      || dstop_rise || (wai && wstop_r);

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         strap_r <= STRAP_WAIT;
         rate_r  <= RATE_OFF;
         win_r   <= 1'b0;
         dstop_r <= 1'b0;
         wstop_r <= 1'b0;
         srun_r  <= 1'b0;
         once_r  <= 1'b0;
      end else if (strap_r != 2'h0) begin
         // straps are read only once both sync stages hold them
         strap_r <= strap_r - 2'h1;
         if (strap_r == 2'h1) begin
            rate_r <= spc ? RATE_MAX : ~opt_rate;
            win_r  <= spc ? 1'b0 : ~opt_win;
         end
      end else begin
         if (wr_ctl) begin
            dstop_r <= dstop_nxt;
         end
         if (ctl_take) begin
            once_r  <= once_r | !spc;
            wstop_r <= wd[BIT_WSTOP];
            srun_r  <= wd[BIT_SRUN];
            win_r   <= spc ? wd[BIT_WIN] : (win_r | wd[BIT_WIN]);
            if (spc || wd[RATE_MSB:0] != RATE_OFF) begin
               rate_r <= wd[RATE_MSB:0];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n || !enabled || arm_restart) begin
         armed_r <= 1'b0;
      end else if (wr_arm && !arm_bad && wd == ARM_KEY1) begin
         armed_r <= 1'b1;
      end
   end

   // reset request holds until system reset removes it
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rst_req_r <= 1'b0;
      end else if (expire || arm_bad) begin
         rst_req_r <= 1'b1;
      end
   end

   wdt_counter #(
      .CW       (CNT_W)
   ) u_counter (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .tick     (tick),
      .run      (run),
      .clear    (clear),
      .shift    (shift_eff),
      .count    (count),
      .expire   (expire),
      .win_open (win_open)
   );

   ////////////////////////////////////////////////////////////////////////
   // read data and outputs
   assign rd_word = rd_ctl ? {24'h000000, win_r, dstop_r, 1'b0, wstop_r,
                              srun_r, rate_r}
                  : (s_axi_araddr[11:2] == STAT_IDX)
                  ? {28'h0000000, armed_r, once_r, win_open, enabled}
                  : 32'h00000000;

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign wdt_reset_req = rst_req_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   AST_TIMEOUT_RESET: assert property (
      expire |=> wdt_reset_req)
      else $error("timeout did not raise reset request");
   AST_OFF_STILL: assert property (
      !enabled |=> count == '0)
      else $error("counter moved while disabled");
   AST_BAD_ARM: assert property (
      (wr_arm && enabled && wd != ARM_KEY1 && wd != ARM_KEY2)
      |=> wdt_reset_req)
      else $error("bad arm value did not reset");
   AST_EARLY_WINDOW: assert property (
      (wr_arm && enabled && win_eff && !win_open) |=> wdt_reset_req)
      else $error("early windowed arm write did not reset");
   AST_ARM_IDLE: assert property (
      (wr_arm && !enabled && !expire && !wdt_reset_req)
      |=> !wdt_reset_req)
      else $error("arm write acted while disabled");
   AST_ARM_READ_ZERO: assert property (
      (rd_fire && s_axi_araddr[11:2] == ARM_IDX) |=> s_axi_rdata == 32'h0)
      else $error("arm register read nonzero");
   AST_WRITE_ONCE: assert property (
      (wr_ctl && once_r && !spc && strap_r == 2'h0) |=> $stable(rate_r))
      else $error("rate changed after single write");
   AST_DSTOP_STICKY: assert property (
      (dstop_r && !spc) |=> dstop_r)
      else $error("debug_stop cleared outside special mode");
   AST_FORCED_MAX: assert property (
      forced |-> (shift_eff == SHIFT_MAX && !win_eff))
      else $error("forced mode not at longest timeout");
   AST_DEBUG_FREEZE: assert property (
      (dbg && dstop_r && enabled && !clear) |=> $stable(count))
      else $error("counter ran in halted debug");

   COV_RESTART: cover property (arm_restart);
   COV_TIMEOUT: cover property (expire);
   COV_WINDOW_OK: cover property (wr_arm && win_eff && win_open);
endmodule

//--- verification/wdt_top_bench.sv
// self-checking bench for the windowed watchdog top level
`timescale 1ns/100ps
module wdt_top_bench;
   import wdt_pkg::*;
   localparam logic [11:0] A_CTL = {CTL_IDX, 2'b00};
   localparam logic [11:0] A_ARM = {ARM_IDX, 2'b00};
   localparam logic [11:0] A_BAD = 12'h200;
   localparam logic [11:0] A_STAT = {STAT_IDX, 2'b00};
   logic        clk_sys, reset_n, debug_mode, wait_mode, stop_mode;
   logic        special_mode, opt_win, req;
   logic [2:0]  opt_rate;
   logic [11:0] awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   int          n_errors, compares, cycles;

   // tick every clock keeps the periods short in simulation
   wdt_top #(.REF_DIVIDE(1)) DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .debug_mode(debug_mode),
      .wait_mode(wait_mode), .stop_mode(stop_mode),
      .special_mode(special_mode), .option_rate_field(opt_rate),
      .option_window_bit(opt_win), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .wdt_reset_req(req));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard, well above the few thousand cycles needed
   initial begin
      cycles = 0;
      forever begin
         @(posedge clk_sys);
         cycles++;
         if (cycles == 20000) begin
            n_errors++;
            $display("[FAIL] run length expected done seen hang");
            give_verdict();
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_flag(input string what, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // each channel held until its own ready, bready up until bvalid
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic aw_ok, w_ok;
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_ok = 1'b1;
         end
         if (wready === 1'b1) begin
            wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [11:0] a);
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // request is sticky, so one look at the end covers the whole span
   task automatic quiet(input int n);
      repeat (n) @(posedge clk_sys);
      chk_flag("reset_req quiet", 1'b0, req);
   endtask

   task automatic fire(input int n);
      for (int i = 0; i < n && req !== 1'b1; i++) @(posedge clk_sys);
      chk_flag("reset_req fired", 1'b1, req);
   endtask

   task automatic do_reset(input logic [2:0] f, input logic w,
                           input logic sp, input logic [2:0] m);
      @(posedge clk_sys);
      reset_n      <= 1'b0;
      opt_rate     <= f;
      opt_win      <= w;
      special_mode <= sp;
      {debug_mode, wait_mode, stop_mode} <= m;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      // straps land three edges after release
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic done(input string t);
      $display("test %s ended, mismatches so far %0d", t, n_errors);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      {debug_mode, wait_mode, stop_mode, special_mode} = 4'h0;
      opt_rate = 3'h0;
      opt_win = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      n_errors = 0;
      compares = 0;
      do_reset(3'h6, 1'b1, 1'b0, 3'h0);
      rdr(A_CTL); chk("control", 32'h00000001, rd);
      rdr(A_ARM); chk("arm read", 32'h00000000, rd);
      rdr(A_BAD); chk("unmapped rresp", 32'h00000002, {30'h0, rs});
      wr(A_BAD, 8'h01); chk("unmapped bresp", 32'h00000002, {30'h0, rs});
      repeat (4) begin
         wr(A_ARM, 8'h55);
         wr(A_ARM, 8'hAA);
         repeat (30) @(posedge clk_sys);
      end
      quiet(30);
      fire(8);
      done("service");
      do_reset(3'h6, 1'b1, 1'b0, 3'h0);
      wr(A_ARM, 8'h12);
      fire(4);
      done("bad_arm");
      do_reset(3'h7, 1'b1, 1'b0, 3'h0);
      wr(A_ARM, 8'h12);
      quiet(100);
      wr(A_CTL, 8'h22);
      rdr(A_CTL); chk("masked control", 32'h00000000, rd);
      wr(A_CTL, 8'h01);
      wr(A_CTL, 8'h03);
      rdr(A_CTL); chk("write once", 32'h00000001, rd);
      quiet(40);
      fire(40);
      done("enable");
      do_reset(3'h6, 1'b0, 1'b0, 3'h0);
      rdr(A_CTL); chk("window control", 32'h00000081, rd);
      wr(A_ARM, 8'h55);
      fire(4);
      done("window_early");
      do_reset(3'h5, 1'b0, 1'b0, 3'h0);
      repeat (200) @(posedge clk_sys);
      wr(A_ARM, 8'h55);
      wr(A_ARM, 8'h55);
      wr(A_ARM, 8'hAA);
      quiet(150);
      fire(300);
      done("window_late");
      do_reset(3'h6, 1'b1, 1'b0, 3'h1);
      quiet(300);
      @(posedge clk_sys);
      stop_mode <= 1'b0;
      fire(100);
      do_reset(3'h6, 1'b1, 1'b0, 3'h2);
      fire(100);
      // wait_stop and stop_run both set by the single control write
      do_reset(3'h6, 1'b1, 1'b0, 3'h2);
      wr(A_CTL, 8'h19);
      quiet(200);
      @(posedge clk_sys);
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      fire(100);
      done("low_power");
      do_reset(3'h6, 1'b1, 1'b0, 3'h4);
      wr(A_CTL, 8'h40);
      quiet(300);
      wr(A_CTL, 8'h03);
      rdr(A_CTL); chk("debug control", 32'h00000041, rd);
      @(posedge clk_sys);
      debug_mode <= 1'b0;
      fire(100);
      done("debug");
      do_reset(3'h6, 1'b1, 1'b1, 3'h0);
      rdr(A_CTL); chk("special control", 32'h00000007, rd);
      wr(A_CTL, 8'h02);
      wr(A_CTL, 8'h03);
      rdr(A_CTL); chk("special rewrite", 32'h00000003, rd);
      done("special");
      // special debug session: short windowed setting must be overridden
      do_reset(3'h6, 1'b1, 1'b1, 3'h4);
      wr(A_CTL, 8'h81);
      chk("control bresp", 32'h00000000, {30'h0, rs});
      wr(A_ARM, 8'h55);
      quiet(100);
      rdr(A_STAT); chk("status", 32'h00000009, rd);
      done("forced");
      give_verdict();
   end
endmodule
